// [core/sck_map.svh]
// register map, field positions, reset values and counts for the checker
`ifndef SCK_MAP_SVH
`define SCK_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SCK_OFS_DELAY_CELL_UPPER 8'h5F
`define SCK_OFS_CHECK_CTRL       8'h60
`define SCK_OFS_REF0_LOW         8'h61
`define SCK_OFS_REF0_HIGH        8'h62
`define SCK_OFS_REF1_LOW         8'h63
`define SCK_OFS_REF1_HIGH        8'h64
`define SCK_OFS_REF2_LOW         8'h65
`define SCK_OFS_REF2_HIGH        8'h66
`define SCK_OFS_REF3_LOW         8'h67
`define SCK_OFS_REF3_HIGH        8'h68
`define SCK_OFS_PARITY_CTRL      8'h6A
`define SCK_OFS_RISE_ERR_COUNT   8'h6B
`define SCK_OFS_FALL_ERR_COUNT   8'h6C
`define SCK_OFS_REVISION         8'h7F

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SCK_CC_COMPARE_EN        7
`define SCK_CC_ERR_CLEAR         6
`define SCK_CC_AUTO_EN           5
`define SCK_CC_DEPTH             4
`define SCK_CC_AUTO_PASS         2
`define SCK_CC_AUTO_FAIL         1
`define SCK_CC_COMPARE_FAIL      0
`define SCK_PC_ENABLE            7
`define SCK_PC_EVEN              6
`define SCK_PC_ERR_CLEAR         5
`define SCK_PC_FALL_FLAG         1
`define SCK_PC_RISE_FLAG         0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SCK_RST_DELAY_CELL_UPPER 8'h67
`define SCK_RST_ZERO             8'h00

// ----------------------------------------------------------------------------
// counts
// ----------------------------------------------------------------------------
`define SCK_PASS_SETS            8
`define SCK_COUNT_MAX            8'hFF

`endif

// [core/sck_pkg.sv]
// types shared by the sample checker
package sck_pkg;

    typedef struct packed {
        logic [15:0] data;
        logic        parity;
    } sck_word_s;

    typedef struct packed {
        logic rise;
        logic fall;
    } sck_edge_s;

endpackage

// [core/sck_top.sv]
// sample pattern comparison and parity checker with its register file
`timescale 1ns/10ps
`include "sck_map.svh"

// Overview of operation
// - pattern comparison runs only while control bit 7 is one.
// - control bit 6 at one clears status bits 2, 1 and 0.
// - with auto-clear, error flags clear after eight consecutive passing sets.
// - control bit 4 selects two-word or four-word comparison sets.
// - with auto-clear, pass bit 2 rises after eight fully matching sets.
// - with auto-clear, fail bit 1 sets on any mismatching compared word.
// - status bit 0 sets on any mismatch, plain or auto-clear mode.
// - reference word 0, rising edge, bytes at 0x61 and 0x62.
// - reference word 1, falling edge, bytes at 0x63 and 0x64.
// - reference word 2, rising edge, bytes at 0x65 and 0x66.
// - reference word 3, falling edge, bytes at 0x67 and 0x68.
// - parity control bit 5 at one resets both parity error counters.
// - parity flag bit 1 sets on a falling-edge parity error.
// - parity flag bit 0 sets on a rising-edge parity error.
// - rising-edge parity errors counted at 0x6B, saturating.
// - falling-edge parity errors counted at 0x6C, saturating.
// - bits 2..0 of 0x5F enable delay cells 10..8, reset enabled.
module sck_top #(
    parameter int         PASS_SETS = `SCK_PASS_SETS,
    parameter logic [7:0] REVISION  = 8'h5A  // arbitrary value
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      logic [7:0]  reg_rdata,
    input  wire logic        link_clk,
    input  wire logic [15:0] link_data,
    input  wire logic        link_parity,
    output      logic [2:0]  delay_cell_en_upper,
    output      logic        compare_fail_flag
);

    // the pass counter is four bits wide
    if (PASS_SETS < 1 || PASS_SETS > 15) begin : g_bad_pass_sets
        $error("PASS_SETS must lie in 1..15");
    end

    localparam logic [3:0] PASS_LAST = 4'(PASS_SETS - 1);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic parity_bad(input sck_pkg::sck_word_s w,
                                        input logic even);
        logic ones;
        ones = ^{w.data, w.parity};
        parity_bad = even ? ones : ~ones;
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == `SCK_COUNT_MAX) ? v : v + 8'h01;
    endfunction

    // ------------------------------------------------------------------------
    // link synchroniser and edge finder
    // ------------------------------------------------------------------------
    sck_pkg::sck_word_s word_s1;
    sck_pkg::sck_word_s word_s2;
    sck_pkg::sck_word_s word_s3;
    logic [2:0]         clk_sync;
    logic               clk_level;
    sck_pkg::sck_edge_s edge_now;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            word_s1  <= '0;
            word_s2  <= '0;
            word_s3  <= '0;
            clk_sync <= 3'h0;
        end else begin
            word_s1  <= '{data: link_data, parity: link_parity};
            word_s2  <= word_s1;
            word_s3  <= word_s2;
            clk_sync <= {clk_sync[1:0], link_clk};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_level <= 1'b0;
        end else if (clk_sync[1] == clk_sync[2]) begin
            clk_level <= clk_sync[2];
        end
    end

    always_comb begin
        edge_now.rise = (clk_sync[1] == clk_sync[2]) &&  clk_sync[2]
                        && !clk_level;
        edge_now.fall = (clk_sync[1] == clk_sync[2]) && !clk_sync[2]
                        &&  clk_level;
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [7:0]  delay_upper;
    logic        compare_en;
    logic        err_clear;
    logic        auto_en;
    logic        depth_four;
    logic        auto_pass_flag;
    logic        auto_fail_flag;
    logic [15:0] ref_word [4];
    logic        par_en;
    logic        par_even;
    logic        par_clear;
    logic        fall_edge_parity_flag;
    logic        rise_edge_parity_flag;
    logic [7:0]  rise_count;
    logic [7:0]  fall_count;

    wire wr_ctrl = reg_wr && reg_addr == `SCK_OFS_CHECK_CTRL;
    wire wr_par  = reg_wr && reg_addr == `SCK_OFS_PARITY_CTRL;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            delay_upper <= `SCK_RST_DELAY_CELL_UPPER;
        end else if (reg_wr && reg_addr == `SCK_OFS_DELAY_CELL_UPPER) begin
            delay_upper <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            compare_en <= 1'b0;
            err_clear  <= 1'b0;
            auto_en    <= 1'b0;
            depth_four <= 1'b0;
        end else if (wr_ctrl) begin
            compare_en <= reg_wdata[`SCK_CC_COMPARE_EN];
            err_clear  <= reg_wdata[`SCK_CC_ERR_CLEAR];
            auto_en    <= reg_wdata[`SCK_CC_AUTO_EN];
            depth_four <= reg_wdata[`SCK_CC_DEPTH];
        end
    end

    // reference words, low byte at even index 0, high byte next
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                ref_word[i] <= 16'h0000;
            end
        end else if (reg_wr && reg_addr >= `SCK_OFS_REF0_LOW
                     && reg_addr <= `SCK_OFS_REF3_HIGH) begin
            if (reg_addr[0]) begin
                ref_word[2'((reg_addr - `SCK_OFS_REF0_LOW) >> 1)][7:0]
                    <= reg_wdata;
            end else begin
                ref_word[2'((reg_addr - `SCK_OFS_REF0_LOW) >> 1)][15:8]
                    <= reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            par_en    <= 1'b0;
            par_even  <= 1'b0;
            par_clear <= 1'b0;
        end else if (wr_par) begin
            par_en    <= reg_wdata[`SCK_PC_ENABLE];
            par_even  <= reg_wdata[`SCK_PC_EVEN];
            par_clear <= reg_wdata[`SCK_PC_ERR_CLEAR];
        end
    end

    // ------------------------------------------------------------------------
    // pattern comparison
    // ------------------------------------------------------------------------
    logic [1:0] pos;
    logic       armed;
    logic       set_bad;
    logic [3:0] pass_cnt;
    logic       word_ev;
    logic       mismatch;
    logic       set_end;
    logic       set_pass;

    // comparison waits for a rising edge so word 0 lines up with it
    always_comb begin
        word_ev  = compare_en && (edge_now.rise || (armed && edge_now.fall));
        mismatch = word_ev && (word_s3.data != ref_word[armed ? pos : 2'h0]);
        set_end  = word_ev && armed
                   && pos == (depth_four ? 2'h3 : 2'h1);
        set_pass = set_end && !set_bad && !mismatch;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pos     <= 2'h0;
            armed   <= 1'b0;
            set_bad <= 1'b0;
        end else if (!compare_en) begin
            pos     <= 2'h0;
            armed   <= 1'b0;
            set_bad <= 1'b0;
        end else if (word_ev) begin
            if (!armed) begin
                armed   <= 1'b1;
                pos     <= 2'h1;
                set_bad <= mismatch;
            end else if (set_end) begin
                pos     <= 2'h0;
                set_bad <= 1'b0;
                armed   <= 1'b0;
            end else begin
                pos     <= pos + 2'h1;
                set_bad <= set_bad | mismatch;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pass_cnt <= 4'h0;
        end else if (!auto_en || !compare_en || mismatch) begin
            pass_cnt <= 4'h0;
        end else if (set_end) begin
            pass_cnt <= (!set_pass || pass_cnt == PASS_LAST) ? 4'h0
                        : pass_cnt + 4'h1;
        end
    end

    wire auto_pass_now = auto_en && set_pass && pass_cnt == PASS_LAST;

    // a new mismatch wins over every clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            compare_fail_flag <= 1'b0;
            auto_fail_flag    <= 1'b0;
        end else if (mismatch) begin
            compare_fail_flag <= 1'b1;
            auto_fail_flag    <= auto_en;
        end else if (err_clear || auto_pass_now) begin
            compare_fail_flag <= 1'b0;
            auto_fail_flag    <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            auto_pass_flag <= 1'b0;
        end else if (auto_pass_now) begin
            auto_pass_flag <= 1'b1;
        end else if (err_clear || mismatch
                     || (wr_ctrl && !reg_wdata[`SCK_CC_AUTO_PASS])) begin
            auto_pass_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // parity check
    // ------------------------------------------------------------------------
    wire par_bad   = par_en && parity_bad(word_s3, par_even);
    wire rise_perr = par_bad && edge_now.rise;
    wire fall_perr = par_bad && edge_now.fall;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rise_edge_parity_flag <= 1'b0;
            fall_edge_parity_flag <= 1'b0;
        end else begin
            rise_edge_parity_flag <= rise_perr
                                     || (rise_edge_parity_flag && !par_clear);
            fall_edge_parity_flag <= fall_perr
                                     || (fall_edge_parity_flag && !par_clear);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rise_count <= 8'h00;
            fall_count <= 8'h00;
        end else if (par_clear) begin
            rise_count <= 8'h00;
            fall_count <= 8'h00;
        end else begin
            if (rise_perr) begin
                rise_count <= sat_inc(rise_count);
            end
            if (fall_perr) begin
                fall_count <= sat_inc(fall_count);
            end
        end
    end

    // ------------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            `SCK_OFS_DELAY_CELL_UPPER: next_rdata = delay_upper;
            `SCK_OFS_CHECK_CTRL:
                next_rdata = {compare_en, err_clear, auto_en, depth_four,
                              1'b0, auto_pass_flag, auto_fail_flag,
                              compare_fail_flag};
            `SCK_OFS_REF0_LOW:  next_rdata = ref_word[0][7:0];
            `SCK_OFS_REF0_HIGH: next_rdata = ref_word[0][15:8];
            `SCK_OFS_REF1_LOW:  next_rdata = ref_word[1][7:0];
            `SCK_OFS_REF1_HIGH: next_rdata = ref_word[1][15:8];
            `SCK_OFS_REF2_LOW:  next_rdata = ref_word[2][7:0];
            `SCK_OFS_REF2_HIGH: next_rdata = ref_word[2][15:8];
            `SCK_OFS_REF3_LOW:  next_rdata = ref_word[3][7:0];
            `SCK_OFS_REF3_HIGH: next_rdata = ref_word[3][15:8];
            `SCK_OFS_PARITY_CTRL:
                next_rdata = {par_en, par_even, par_clear, 3'h0,
                              fall_edge_parity_flag, rise_edge_parity_flag};
            `SCK_OFS_RISE_ERR_COUNT: next_rdata = rise_count;
            `SCK_OFS_FALL_ERR_COUNT: next_rdata = fall_count;
            `SCK_OFS_REVISION:       next_rdata = REVISION;
            default:                 next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            delay_cell_en_upper <= 3'h7;
        end else begin
            delay_cell_en_upper <= delay_upper[2:0];
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_mismatch_seen;
        mismatch ##1 compare_fail_flag;
    endsequence

    chk_idle_no_words: assert property (
        !compare_en |=> !$rose(compare_fail_flag))
        else $error("comparison active while disabled");
    chk_clear_flags: assert property (
        err_clear && !mismatch && !auto_pass_now
        |=> !compare_fail_flag && !auto_fail_flag && !auto_pass_flag)
        else $error("error clear left a flag set");
    chk_auto_clear: assert property (
        auto_pass_now |=> !compare_fail_flag && auto_pass_flag)
        else $error("auto clear did not act");
    chk_depth_two: assert property (
        set_end && !depth_four |-> edge_now.fall && pos == 2'h1)
        else $error("two-word set ended at wrong word");
    chk_pass_after: assert property (
        $rose(auto_pass_flag)
        |-> $past(pass_cnt) == PASS_LAST && $past(auto_en))
        else $error("pass flag without full passing run");
    chk_auto_fail: assert property (
        mismatch && auto_en |=> auto_fail_flag)
        else $error("auto fail flag missed a mismatch");
    chk_fail_flag: assert property (s_mismatch_seen or !mismatch)
        else $error("compare fail flag missed a mismatch");
    chk_parity_clr: assert property (
        par_clear |=> rise_count == 8'h00 && fall_count == 8'h00)
        else $error("parity counters not cleared");
    chk_fall_flag: assert property (
        fall_perr |=> fall_edge_parity_flag)
        else $error("falling parity flag missed");
    chk_rise_flag: assert property (
        rise_perr |=> rise_edge_parity_flag)
        else $error("rising parity flag missed");
    chk_rise_count: assert property (
        rise_perr && !par_clear
        |=> rise_count == sat_inc($past(rise_count)))
        else $error("rising count wrong");
    chk_fall_sat: assert property (
        $past(fall_count) == 8'hFF && !$past(par_clear)
        |-> fall_count == 8'hFF)
        else $error("falling count wrapped");
    chk_delay_out: assert property (
        ##1 delay_cell_en_upper == $past(delay_upper[2:0]))
        else $error("delay cell enables out of step");
    chk_parity_off: assert property (
        !par_en |=> ($stable(rise_count) || rise_count == 8'h00)
        && ($stable(fall_count) || fall_count == 8'h00))
        else $error("parity counted while disabled");

endmodule

// [tb/sck_src.sv]
// link source model driving ddr sample words and their strobe
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// source
// ----------------------------------------------------------------------------
module sck_src (
    output logic               link_clk,
    output sck_pkg::sck_word_s link_w
);
    initial begin
        link_clk = 1'b0;
        link_w   = '0;
    end

    // one word per strobe edge; strobe stands still between frames
    task automatic put(input sck_pkg::sck_word_s w);
        link_w = w;
        #50;
        link_clk = ~link_clk;
        #350;
    endtask

    // released word no longer shows its last value
    task automatic idle();
        link_w = ~link_w;
    endtask
endmodule

// [tb/sck_top_tb.sv]
// self-checking bench for the sample checker
`timescale 1ns/10ps
module sck_top_tb;
    localparam logic [7:0] REV = 8'h3C;  // arbitrary value
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    logic [7:0]         reg_addr = 8'h00;
    logic [7:0]         reg_wdata = 8'h00;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [7:0]         reg_rdata;
    logic               link_clk;
    sck_pkg::sck_word_s link_w;
    logic [2:0]         cells;
    logic               fail_pin;
    integer             seed = 32'h1cef;
    int                 bad_count = 0;
    int                 tests_run = 0;
    logic [15:0]        refw [4];
    logic [7:0]         got;
    int                 cctl = 0, pass = 0, fail1 = 0, fail0 = 0, runs = 0;
    int                 pctl = 0, rcnt = 0, fcnt = 0, rflag = 0, fflag = 0;
    bit                 rise_next = 1'b1;

    always #50 sys_clk = ~sys_clk;

    sck_top #(.PASS_SETS(8), .REVISION(REV)) DUT (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .link_clk(link_clk),
        .link_data(link_w.data), .link_parity(link_w.parity),
        .delay_cell_en_upper(cells), .compare_fail_flag(fail_pin));

    sck_src src (.link_clk(link_clk), .link_w(link_w));

    // ------------------------------------------------------------------------
    // register port and model
    // ------------------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        if (a == 8'h60) begin
            cctl = d & 8'hF0;
            pass = 0;
            fail0 = d[6] ? 0 : fail0;
            fail1 = d[6] ? 0 : fail1;
            runs = 0;
        end
        if (a == 8'h6A) begin
            pctl = d & 8'hE0;
            // clear level also empties both flags
            if (d[5]) {rcnt, fcnt, rflag, fflag} = '0;
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(posedge sys_clk);
        #1 got = reg_rdata;
        chk($sformatf("reg %h", a), e, got);
    endtask

    task automatic cmp_state();
        rc(8'h60, 8'(cctl + pass * 4 + fail1 * 2 + fail0));
        chk("fail pin", 8'(fail0), {7'h00, fail_pin});
    endtask

    task automatic par_state();
        rc(8'h6A, 8'(pctl + fflag * 2 + rflag));
        rc(8'h6B, 8'(rcnt));
        rc(8'h6C, 8'(fcnt));
    endtask

    // n words from the reference list; word badw inverted; pm picks
    // parity faults: 0 none, 1 random, 2 on every word
    task automatic frame(input int n, input int badw, input int pm);
        logic [15:0] w;
        bit          bp;
        logic        p;
        @(posedge sys_clk);
        #20;
        for (int i = 0; i < n; i++) begin
            w = refw[i % 4];
            if (i == badw) w = ~w;
            bp = pm == 2 ? 1'b1 : pm == 1 ? bit'($random(seed)) : 1'b0;
            p = (pctl[6] ? ^w : ~^w) ^ bp;
            src.put({w, p});
            if (pctl[7] && bp) begin
                if (rise_next) rcnt = rcnt > 254 ? 255 : rcnt + 1;
                else fcnt = fcnt > 254 ? 255 : fcnt + 1;
                if (rise_next) rflag = 1;
                else fflag = 1;
            end
            rise_next = !rise_next;
        end
        src.idle();
        if (cctl[7] && badw >= 0 && badw < n) begin
            fail0 = 1;
            fail1 = cctl[5] ? 1 : fail1;
            pass = 0;
            runs = 0;
        end else if (cctl[7] && ++runs == 8 && cctl[5]) begin
            pass = 1;
            fail0 = 0;
            fail1 = 0;
            runs = 0;
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        chk("cells", 8'h07, {5'h00, cells});
        for (int a = 8'h5F; a <= 8'h7F; a++)
            rc(8'(a), a == 8'h5F ? 8'h67 : a == 8'h7F ? REV : 8'h00);
        wr(8'h6B, 8'hFF);
        wr(8'h7F, 8'h00);
        rc(8'h6B, 8'h00);
        rc(8'h7F, REV);
        for (int i = 0; i < 4; i++) begin
            refw[i] = 16'($random(seed));
            wr(8'(8'h61 + 2 * i), refw[i][7:0]);
            wr(8'(8'h62 + 2 * i), refw[i][15:8]);
            rc(8'(8'h61 + 2 * i), refw[i][7:0]);
            rc(8'(8'h62 + 2 * i), refw[i][15:8]);
        end
        for (int k = 7; k >= 0; k--) begin
            wr(8'h5F, 8'(8'h60 + k));
            rc(8'h5F, 8'(8'h60 + k));
            chk("cells", 8'(k), {5'h00, cells});
        end
        frame(4, 1, 0);
        cmp_state();
        wr(8'h80, 8'h00);
        wr(8'h60, 8'h80);
        frame(2, -1, 0);
        frame(2, -1, 0);
        cmp_state();
        frame(2, 1, 0);
        cmp_state();
        wr(8'h60, 8'hC0);
        cmp_state();
        wr(8'h60, 8'hB0);
        repeat (8) frame(4, -1, 0);
        cmp_state();
        frame(4, $unsigned($random(seed)) % 4, 0);
        cmp_state();
        repeat (7) frame(4, -1, 0);
        cmp_state();
        frame(4, -1, 0);
        cmp_state();
        wr(8'h60, 8'h00);
        frame(4, -1, 1);
        par_state();
        for (int pol = 0; pol < 2; pol++) begin
            wr(8'h6A, 8'(8'h80 + pol * 64));
            frame(8, -1, 1);
            par_state();
        end
        wr(8'h6A, 8'hA0);
        par_state();
        wr(8'h6A, 8'h80);
        frame(520, -1, 2);
        par_state();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end
endmodule
